// ---- rtl/fast_clock_map.vh ----
// register map, field positions and reset values of the fast clock control block
`ifndef FAST_CLOCK_MAP_VH
`define FAST_CLOCK_MAP_VH

// register byte address
`define FCC_ADDR_CONTROL      12'h000
`define FCC_ADDR_W            12

// field positions
`define FCC_LOCK_BIT          15
`define FCC_FAST_STOP_BIT     13
`define FCC_SLOW_STOP_BIT     12
`define FCC_PLL_EN_BIT        10
`define FCC_XTAL_EN_BIT       9
`define FCC_SYS_SEL_BIT       8
`define FCC_OUT_DIV_HI        7
`define FCC_OUT_DIV_LO        5
`define FCC_SRC_HI            4
`define FCC_SRC_LO            3
`define FCC_SYS_DIV_HI        2
`define FCC_SYS_DIV_LO        0

// reset values
`define FCC_OUT_DIV_RESET     3'h3
`define FCC_SRC_RESET         2'h0
`define FCC_SYS_DIV_RESET     3'h3

// flash wait-cycle settings and the least divider codes they force
`define FCC_FLASH_SLOW        2'h0
`define FCC_FLASH_MID         2'h1
`define FCC_MIN_DIV_ONE       3'h1
`define FCC_MIN_DIV_TWO       3'h2
`define FCC_MIN_DIV_THREE     3'h3

// axi response codes
`define FCC_RESP_OKAY         2'h0
`define FCC_RESP_SLVERR       2'h2

`endif

// ---- rtl/level_sync.v ----
// two-flop synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
module level_sync (
    input  wire mclk,
    input  wire rst_b,
    input  wire din,
    output reg  dout
);
    reg first_stage;

    // first stage is read only by the second stage
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            first_stage <= 1'b0;
            dout        <= 1'b0;
        end else begin
            first_stage <= din;
            dout        <= first_stage;
        end
    end
endmodule // level_sync

// ---- rtl/pow2_divider.v ----
// power-of-two divider giving a one-cycle tick every 2^code source cycles
`timescale 1ns/1ns
module pow2_divider (
    input  wire       mclk,
    input  wire       rst_b,
    input  wire [2:0] code,
    output reg        tick
);
    reg  [6:0] count;
    wire [6:0] last;

    assign last = (7'h01 << code) - 7'h01;

    // count restarts whenever it reaches or passes the terminal value
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 7'h00;
            tick  <= 1'b0;
        end else if (count >= last) begin
            count <= 7'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 7'h01;
            tick  <= 1'b0;
        end
    end
endmodule // pow2_divider

// ---- rtl/fast_clock_control.v ----
// fast clock control register with axi4-lite access and clock dividers
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "fast_clock_map.vh"
module fast_clock_control (
    input  wire        mclk,
    input  wire        rst_b,
    // axi4-lite write address
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [11:0] s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    // axi4-lite write data
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // axi4-lite read address
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    input  wire [11:0] s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    // axi4-lite read data
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // clock generator status and neighbours
    input  wire        pll_locked,
    input  wire        pll_lock_timeout_flag,
    input  wire        xtal_settle_timeout_flag,
    input  wire        xtal_stop_flag,
    input  wire        fast_xtal_half_freq,
    input  wire [1:0]  flash_wait_cycles,
    input  wire        stop_mode_req,
    // controls toward the clock generator
    output reg         pll_enable,
    output reg         fast_xtal_enable,
    output reg         system_clock_select,
    output reg         fast_xtal_stop_detect_en,
    output reg         slow_xtal_stop_detect_en,
    output reg  [2:0]  effective_system_divider,
    output reg         divided_fast_clock,
    output reg         fast_clock_out_pin
);
    // register fields
    reg  [2:0]  output_clock_divider;
    reg  [1:0]  fast_source_select;
    reg  [2:0]  system_divider_select;

    // axi bookkeeping
    reg         aw_held;
    reg  [11:0] aw_addr;
    reg         w_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;

    // next values
    reg         next_pll_enable;
    reg         next_fast_xtal_enable;
    reg         next_system_clock_select;
    reg  [1:0]  next_fast_source_select;
    reg  [2:0]  next_effective_div;

    wire        pll_lock_flag;
    wire        sys_tick;
    wire        out_tick;
    wire        do_write;
    wire        write_hit;
    wire        lo_lane;
    wire        hi_lane;
    wire [31:0] control_word;

    // least divider code allowed for the source frequency and flash wait
    function [2:0] min_divider;
        input       xtal_src;
        input       half_freq;
        input [1:0] wait_cycles;
        begin
            // the slowest flash setting needs the deepest floor, the fastest none
            min_divider = 3'h0;
            if (!xtal_src) begin
                if (wait_cycles == `FCC_FLASH_SLOW)
                    min_divider = `FCC_MIN_DIV_THREE;
                else if (wait_cycles == `FCC_FLASH_MID)
                    min_divider = `FCC_MIN_DIV_ONE;
            end else if (!half_freq) begin
                if (wait_cycles == `FCC_FLASH_SLOW)
                    min_divider = `FCC_MIN_DIV_TWO;
                else if (wait_cycles == `FCC_FLASH_MID)
                    min_divider = `FCC_MIN_DIV_ONE;
            end else begin
                if (wait_cycles == `FCC_FLASH_SLOW)
                    min_divider = `FCC_MIN_DIV_ONE;
            end
        end
    endfunction

    // true when an address selects the control register
    function addr_hit;
        input [11:0] addr;
        begin
            addr_hit = (addr == `FCC_ADDR_CONTROL);
        end
    endfunction

    // lock level comes from the analog pll, so it is synchronised
    level_sync lock_sync (
        .mclk  (mclk),
        .rst_b (rst_b),
        .din   (pll_locked),
        .dout  (pll_lock_flag)
    );

    // divided fast clock for the system, by the effective code
    pow2_divider sys_divider (
        .mclk  (mclk),
        .rst_b (rst_b),
        .code  (effective_system_divider),
        .tick  (sys_tick)
    );

    // output clock pin divider, code 0 passes every cycle
    pow2_divider out_divider (
        .mclk  (mclk),
        .rst_b (rst_b),
        .code  (output_clock_divider),
        .tick  (out_tick)
    );

    // read view of the register, unused bits zero
    assign control_word = {16'h0000,
                           pll_lock_flag,
                           1'b0,
                           fast_xtal_stop_detect_en,
                           slow_xtal_stop_detect_en,
                           1'b0,
                           pll_enable,
                           fast_xtal_enable,
                           system_clock_select,
                           output_clock_divider,
                           fast_source_select,
                           system_divider_select};

    // a write lands only with both halves held and no response pending
    assign do_write  = aw_held && w_held && !s_axi_bvalid;
    assign write_hit = do_write && addr_hit(aw_addr);
    assign lo_lane   = write_hit && w_strb[0];
    assign hi_lane   = write_hit && w_strb[1];

    // write address and data are taken independently, one write at a time
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_held       <= 1'b0;
            aw_addr       <= 12'h000;
            w_held        <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FCC_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
            // address half, kept until the data half arrives
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            // data half with its lane strobes
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            // both halves held: register updates and the response rises together
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_hit(aw_addr) ? `FCC_RESP_OKAY : `FCC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel, answer one cycle after the address is taken
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `FCC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
            // data is captured with the address, so it stands unchanged until taken
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                if (addr_hit(s_axi_araddr)) begin
                    s_axi_rdata <= control_word;
                    s_axi_rresp <= `FCC_RESP_OKAY;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `FCC_RESP_SLVERR;
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // gated writes to the enables, source select and system select
    always @* begin
        next_pll_enable          = pll_enable;
        next_fast_xtal_enable    = fast_xtal_enable;
        next_system_clock_select = system_clock_select;
        next_fast_source_select  = fast_source_select;
        // pll enable refused while the crystal is the source or lock timed out
        if (hi_lane && !fast_source_select[0] && !pll_lock_timeout_flag) begin
            next_pll_enable = w_data[`FCC_PLL_EN_BIT];
        end
        // crystal enable refused while a crystal flag is raised
        if (hi_lane && !xtal_settle_timeout_flag && !xtal_stop_flag) begin
            next_fast_xtal_enable = w_data[`FCC_XTAL_EN_BIT];
        end
        // system select takes any written value, the fallback below may override
        if (hi_lane) begin
            next_system_clock_select = w_data[`FCC_SYS_SEL_BIT];
        end
        // source select moves only while everything it feeds is off
        if (lo_lane && !fast_xtal_enable && !pll_enable && !system_clock_select) begin
            next_fast_source_select = w_data[`FCC_SRC_HI:`FCC_SRC_LO];
        end
        // a stop request wins over a write to either source enable in the same cycle
        if (stop_mode_req) begin
            next_pll_enable          = 1'b0;
            next_fast_xtal_enable    = 1'b0;
        end
        // losing the selected source falls back to the slow clock
        if ((pll_enable && !next_pll_enable && !fast_source_select[0]) ||
            (fast_xtal_enable && !next_fast_xtal_enable && fast_source_select[0])) begin
            next_system_clock_select = 1'b0;
        end
    end

    // effective system divider, raised to the safe minimum
    always @* begin
        next_effective_div = min_divider(fast_source_select[0],
                                         fast_xtal_half_freq,
                                         flash_wait_cycles);
        if (system_divider_select > next_effective_div)
            next_effective_div = system_divider_select;
    end

    // source enables and system select follow the gated next values
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pll_enable          <= 1'b0;
            fast_xtal_enable    <= 1'b0;
            system_clock_select <= 1'b0;
        end else begin
            pll_enable          <= next_pll_enable;
            fast_xtal_enable    <= next_fast_xtal_enable;
            system_clock_select <= next_system_clock_select;
        end
    end

    // source select, only bit 0 matters to the rest of the logic
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fast_source_select <= `FCC_SRC_RESET;
        end else begin
            fast_source_select <= next_fast_source_select;
        end
    end

    // stop detect enables are plain read/write bits of the upper lane
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fast_xtal_stop_detect_en <= 1'b0;
            slow_xtal_stop_detect_en <= 1'b0;
        end else if (hi_lane) begin
            fast_xtal_stop_detect_en <= w_data[`FCC_FAST_STOP_BIT];
            slow_xtal_stop_detect_en <= w_data[`FCC_SLOW_STOP_BIT];
        end
    end

    // divider fields of the lower lane; prohibited codes are kept and used
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            output_clock_divider  <= `FCC_OUT_DIV_RESET;
            system_divider_select <= `FCC_SYS_DIV_RESET;
        end else if (lo_lane) begin
            output_clock_divider  <= w_data[`FCC_OUT_DIV_HI:`FCC_OUT_DIV_LO];
            system_divider_select <= w_data[`FCC_SYS_DIV_HI:`FCC_SYS_DIV_LO];
        end
    end

    // effective divider is registered so a flash wait change settles first
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            effective_system_divider <= `FCC_SYS_DIV_RESET;
        end else begin
            effective_system_divider <= next_effective_div;
        end
    end

    // system clock tick, one mclk cycle wide
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            divided_fast_clock <= 1'b0;
        end else begin
            divided_fast_clock <= sys_tick;
        end
    end

    // output pin tick; software keeps its rate within the pin limit
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fast_clock_out_pin <= 1'b0;
        end else begin
            fast_clock_out_pin <= out_tick;
        end
    end
endmodule // fast_clock_control

// ---- dv/fast_clock_control_assertions.sv ----
// concurrent checks on the ports of the fast clock control register
`timescale 1ns/1ns
module fast_clock_control_assertions (
    input wire        mclk,
    input wire        rst_b,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        pll_lock_timeout_flag,
    input wire        xtal_settle_timeout_flag,
    input wire        xtal_stop_flag,
    input wire [1:0]  flash_wait_cycles,
    input wire        stop_mode_req,
    input wire        pll_enable,
    input wire        fast_xtal_enable,
    input wire        system_clock_select,
    input wire [2:0]  effective_system_divider
);
    // every check runs on the register clock and rests during reset
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    a_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed before it was taken");
    a_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped or changed before it was taken");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read answer late");
    a_unused_zero:
        assert property (s_axi_rvalid |-> (s_axi_rdata & 32'hFFFF_4800) == 32'h0)
        else $error("unused register bits read nonzero");
    a_stop_clears:
        assert property (stop_mode_req |=> !pll_enable && !fast_xtal_enable)
        else $error("stop request left a source enabled");
    a_pll_refused:
        assert property ($rose(pll_enable) |-> !$past(pll_lock_timeout_flag))
        else $error("pll enable set during lock timeout");
    a_xtal_refused:
        assert property ($rose(fast_xtal_enable) |->
            !$past(xtal_settle_timeout_flag) && !$past(xtal_stop_flag))
        else $error("crystal enable set while a crystal flag was high");
    a_select_drop:
        assert property ($fell(pll_enable) && $fell(fast_xtal_enable) |-> !system_clock_select)
        else $error("system clock select kept after both sources stopped");
    a_div_floor:
        assert property (flash_wait_cycles == 2'h0 |=> effective_system_divider != 3'h0)
        else $error("undivided system clock with slowest flash setting");
endmodule // fast_clock_control_assertions

bind fast_clock_control fast_clock_control_assertions u_chk (.*);

// ---- dv/fast_clock_control_tb.sv ----
// self-checking bench for the fast clock control register
`timescale 1ns/1ns
`include "fast_clock_map.vh"
module fast_clock_control_tb;
    reg         mclk = 1'b0;
    reg         rst_b = 1'b0;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    reg  [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    reg  [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg  [3:0]  s_axi_wstrb = 4'h0;
    reg         pll_locked = 1'b0, pll_lock_timeout_flag = 1'b0, stop_mode_req = 1'b0;
    reg         xtal_settle_timeout_flag = 1'b0, xtal_stop_flag = 1'b0;
    reg         fast_xtal_half_freq = 1'b0;
    reg  [1:0]  flash_wait_cycles = 2'h2;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire        pll_enable, fast_xtal_enable, system_clock_select;
    wire        fast_xtal_stop_detect_en, slow_xtal_stop_detect_en;
    wire [2:0]  effective_system_divider;
    wire        divided_fast_clock, fast_clock_out_pin;
    integer     num_errors = 0;
    integer     check_count = 0;
    reg  [31:0] exp_reg = 32'h0000_0063;
    reg  [31:0] rd;
    reg  [1:0]  rsp;
    integer     i, c, n;

    // 20 MHz register clock
    always #25 mclk = ~mclk;

    fast_clock_control dut (.*);

    task chk(input [31:0] seen, input [31:0] want, input string what);
        begin
            check_count = check_count + 1;
            if (seen !== want) begin
                num_errors = num_errors + 1;
                $display("mismatch %s expected %h seen %h", what, want, seen);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks %0d errors %0d", check_count, num_errors);
            if (num_errors == 0 && check_count > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task tmo(input ok);
        begin
            if (!ok) begin
                num_errors = num_errors + 1;
                final_report;
            end
        end
    endtask

    // axi4-lite write, address and data offered together
    task wr(input [11:0] a, input [31:0] d, input [3:0] s);
        integer k, dly;
        reg     done;
        begin
            // the response is sometimes taken late, so it has to stand
            dly = $urandom % 6;
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= s;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= (dly == 0);
            k = 0;
            do begin
                @(posedge mclk);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
                k = k + 1;
                done = s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1;
                if (!done && k >= dly) s_axi_bready <= 1'b1;
            end while (!done && k < 40);
            rsp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            tmo(done);
            @(posedge mclk);
        end
    endtask

    // axi4-lite read
    task rdreg(input [11:0] a);
        integer k, dly;
        reg     done;
        begin
            // the read data is sometimes taken late, so it has to stand
            dly = $urandom % 6;
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= (dly == 0);
            k = 0;
            do begin
                @(posedge mclk);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
                k = k + 1;
                done = s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1;
                if (!done && k >= dly) s_axi_rready <= 1'b1;
            end while (!done && k < 40);
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            tmo(done);
            @(posedge mclk);
        end
    endtask

    // expected register after a write, flags as currently held
    function [31:0] nxt(input [31:0] o, input [31:0] d, input [3:0] s);
        begin
            nxt = o;
            if (s[0])
                nxt[7:0] = {d[7:5], (o[10:8] == 3'h0) ? d[4:3] : o[4:3], d[2:0]};
            if (s[1]) begin
                nxt[13:12] = d[13:12];
                nxt[8] = d[8];
                if (!o[3] && !pll_lock_timeout_flag) nxt[10] = d[10];
                if (!xtal_settle_timeout_flag && !xtal_stop_flag) nxt[9] = d[9];
            end
            if ((o[10] && !nxt[10] && !o[3]) || (o[9] && !nxt[9] && o[3])) nxt[8] = 1'b0;
        end
    endfunction

    // expected effective divider from field, source and flash wait
    function [2:0] eff(input [2:0] f);
        reg [2:0] m;
        begin
            if (!exp_reg[3])
                m = flash_wait_cycles == 2'h0 ? 3'h3 : flash_wait_cycles == 2'h1 ? 3'h1 : 3'h0;
            else if (!fast_xtal_half_freq)
                m = flash_wait_cycles == 2'h0 ? 3'h2 : flash_wait_cycles == 2'h1 ? 3'h1 : 3'h0;
            else
                m = flash_wait_cycles == 2'h0 ? 3'h1 : 3'h0;
            eff = f > m ? f : m;
        end
    endfunction

    // write, then compare response, outputs and read-back with the model
    task wchk(input [31:0] d, input [3:0] s);
        begin
            wr(`FCC_ADDR_CONTROL, d, s);
            exp_reg = nxt(exp_reg, d, s);
            chk(rsp, `FCC_RESP_OKAY, "bresp");
            chk({fast_xtal_stop_detect_en, slow_xtal_stop_detect_en, pll_enable,
                fast_xtal_enable, system_clock_select}, {exp_reg[13:12], exp_reg[10:8]},
                "control outputs");
            rdreg(`FCC_ADDR_CONTROL);
            chk(rd, exp_reg | {16'h0, pll_locked, 15'h0}, "readback");
            chk(effective_system_divider, eff(exp_reg[2:0]), "effective divider");
        end
    endtask

    // cycles between the second and third tick of a divider output
    task gap(input sel);
        integer k, m, t;
        begin
            m = 0;
            t = 0;
            for (k = 0; k < 600 && m < 3; k = k + 1) begin
                @(posedge mclk);
                if ((sel ? divided_fast_clock : fast_clock_out_pin) === 1'b1) begin
                    m = m + 1;
                    if (m == 2) t = k;
                    if (m == 3) n = k - t;
                end
            end
            tmo(m == 3);
        end
    endtask

    // main sequence
    initial begin
        n = $urandom(32'h3C459470);
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rdreg(`FCC_ADDR_CONTROL);
        chk(rd, 32'h0000_0063, "reset value");
        rdreg(12'h004);
        chk(rd, 32'h0, "unmapped read data");
        chk(rsp, `FCC_RESP_SLVERR, "unmapped read response");
        wr(12'h004, 32'hFFFF_FFFF, 4'hF);
        chk(rsp, `FCC_RESP_SLVERR, "unmapped write");
        for (c = 0; c < 4; c = c + 1) begin
            {pll_lock_timeout_flag, xtal_settle_timeout_flag, xtal_stop_flag} <= 3'h0;
            wchk(32'h0, 4'h2);
            wchk({27'h0, c[1:0], 3'h0}, 4'h1);
            for (i = 0; i < 30; i = i + 1) begin
                {pll_lock_timeout_flag, xtal_settle_timeout_flag, xtal_stop_flag} <= $urandom;
                {pll_locked, fast_xtal_half_freq} <= $urandom;
                flash_wait_cycles <= $urandom % 3;
                rd = $urandom;
                if (rd[7:5] == 3'h0) rd[7:5] = 3'h1;
                if (exp_reg[10:8] == 3'h0) rd[4:3] = exp_reg[4:3];
                wchk(rd, $urandom);
            end
            {pll_lock_timeout_flag, xtal_settle_timeout_flag, xtal_stop_flag} <= 3'h0;
            wchk(exp_reg | 32'h700, 4'h2);
            stop_mode_req <= 1'b1;
            @(posedge mclk);
            stop_mode_req <= 1'b0;
            @(posedge mclk);
            exp_reg = nxt(exp_reg, exp_reg & ~32'h600, 4'h2);
            rdreg(`FCC_ADDR_CONTROL);
            chk(rd[10:8], exp_reg[10:8], "after stop");
        end
        flash_wait_cycles <= 2'h2;
        for (c = 0; c < 8; c = c + 1) begin
            wchk({24'h0, c[2:0], exp_reg[4:3], c[2:0]}, 4'h1);
            gap(1'b0);
            chk(n, 1 << c, "output divider");
            gap(1'b1);
            chk(n, 1 << c, "system divider");
        end
        final_report;
    end
endmodule // fast_clock_control_tb
